// [common/rsu_pkg.sv]
// shared constants and types of the redundancy switch unit
package rsu_pkg;

    // register bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_STATE = 8'h0C;

    // control register fields
    localparam int CTRL_SRC_BIT = 0;
    localparam int CTRL_KIND_LSB = 1;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // status and mask bits, same layout
    localparam int ST_HANDOVER_DONE = 0;
    localparam int ST_MINOR_EVT = 1;
    localparam int ST_MAJOR_EVT = 2;
    localparam int ST_RESYNC_DONE = 3;
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;

    // data kinds offered by a processor each scan
    localparam logic [1:0] KIND_INPUT = 2'h0;
    localparam logic [1:0] KIND_OVERRIDE = 2'h1;
    localparam logic [1:0] KIND_REGISTER = 2'h2;
    localparam logic [1:0] KIND_NONE = 2'h3;

    // master-select keyswitch codes
    localparam logic [1:0] SEL_FIRST = 2'h1;
    localparam logic [1:0] SEL_SECOND = 2'h2;

    // intermediate storage and relays
    localparam int BUF_DEPTH = 16;
    localparam int BUF_AW = 4;
    localparam int RELAY_COUNT = 12;

    // operating states
    typedef enum logic [1:0] {
        ST_HOLD,
        ST_RUN,
        ST_HANDOVER,
        ST_SHUTDOWN
    } rsu_state_type;

endpackage

// [design/rsu_copy_buf.sv]
// intermediate storage for data moving from master to standby
`timescale 1ns/100ps
`default_nettype none
module rsu_copy_buf import rsu_pkg::*; (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic push_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic pop_i,
    output logic [DATA_W-1:0] data_o,
    output logic empty_o,
    output logic full_o
);
    // whole module state in one word
    typedef struct packed {
        logic [BUF_DEPTH-1:0][DATA_W-1:0] mem;
        logic [BUF_AW-1:0] wptr;
        logic [BUF_AW-1:0] rptr;
        logic [BUF_AW:0] count;
        logic [DATA_W-1:0] rdata;
    } rsu_buf_type;

    rsu_buf_type r, next_r;

    // flags straight from the count flop
    assign empty_o = (r.count == '0);
    assign full_o = (r.count == (BUF_AW+1)'(BUF_DEPTH));
    assign data_o = r.rdata;

    // caller never pushes when full nor pops when empty
    always_comb begin
        next_r = r;
        if (push_i) begin
            next_r.mem[r.wptr] = data_i;
            next_r.wptr = r.wptr + BUF_AW'(1);
        end
        if (pop_i) begin
            next_r.rdata = r.mem[r.rptr];
            next_r.rptr = r.rptr + BUF_AW'(1);
        end
        // simultaneous push and pop keeps the count
        next_r.count = r.count + (BUF_AW+1)'(push_i) - (BUF_AW+1)'(pop_i);
    end

    // reset clears the whole state, storage contents and pointers alike
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule
`default_nettype wire

// [design/rsu_relay_drive.sv]
// changeover relays and fail-safe alarm relay drivers
`timescale 1ns/100ps
`default_nettype none
module rsu_relay_drive import rsu_pkg::*; (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic master_i,
    input wire logic minor_i,
    input wire logic major_i,
    output logic [RELAY_COUNT-1:0] relay_o,
    output logic minor_relay_o,
    output logic major_relay_o
);
    // whole module state in one word
    typedef struct packed {
        logic [RELAY_COUNT-1:0] relay;
        logic minor_relay;
        logic major_relay;
    } rsu_relay_type;

    rsu_relay_type r, next_r;
    logic [RELAY_COUNT-1:0] next_relay; // per-coil next value

    assign relay_o = r.relay;
    assign minor_relay_o = r.minor_relay;
    assign major_relay_o = r.major_relay;

    // per-relay coil, set means second processor is master
    for (genvar g = 0; g < RELAY_COUNT; g++) begin : g_relay
        assign next_relay[g] = master_i;
    end

    // each relay coil follows the master only
    always_comb begin
        next_r = r;
        next_r.relay = next_relay;
        // energized while healthy, so a dead unit also alarms
        next_r.minor_relay = !minor_i;
        next_r.major_relay = !major_i;
    end

    // all coils drop during reset: alarms fail-safe
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    a_relay_follow: assert property (@(posedge mclk_i)
        disable iff (rst_i)
        !$past(rst_i) |-> relay_o == {RELAY_COUNT{$past(master_i)}})
        else $error("relays do not follow master");
    a_alarm_failsafe: assert property (@(posedge mclk_i)
        disable iff (rst_i) minor_i ##1 1'b1 |-> !minor_relay_o)
        else $error("minor alarm relay energized under fault");
endmodule
`default_nettype wire

// [design/rsu_top.sv]
// redundancy switch unit: supervision, copy engine and switchover
`timescale 1ns/100ps
`default_nettype none
module rsu_top import rsu_pkg::*; (
    input wire logic mclk_i,
    input wire logic rst_i,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    output logic irq_o,
    // keyswitches and jumpers
    input wire logic run_hold_i,
    input wire logic [1:0] master_sel_i,
    input wire logic [2:0] jumper_kinds_i,
    input wire logic dual_chain_i,
    input wire logic aux_fitted_i,
    // first processor
    input wire logic first_processor_valid_i,
    input wire logic [1:0] first_processor_kind_i,
    input wire logic [DATA_W-1:0] first_processor_data_i,
    input wire logic first_processor_fault_i,
    input wire logic first_processor_online_i,
    // second processor
    input wire logic second_processor_valid_i,
    input wire logic [1:0] second_processor_kind_i,
    input wire logic [DATA_W-1:0] second_processor_data_i,
    input wire logic second_processor_fault_i,
    input wire logic second_processor_online_i,
    // sweep boundary of the current master
    input wire logic sweep_end_i,
    // chain health
    input wire logic chain1_fault_i,
    input wire logic chain2_fault_i,
    input wire logic aux_chain1_fault_i,
    input wire logic aux_chain2_fault_i,
    // standby data path
    output logic [DATA_W-1:0] sby_data_o,
    output logic sby_valid_o,
    output logic sby_dest_o,
    // steering
    output logic io_bus_sel_o,
    output logic io_bus_en_o,
    output logic chain_sel_o,
    output logic aux_chain_sel_o,
    output logic [RELAY_COUNT-1:0] relay_o,
    output logic minor_relay_o,
    output logic major_relay_o
);
    // whole block state in one word
    typedef struct packed {
        rsu_state_type st;
        logic master;            // 0 first, 1 second
        logic chain;             // 0 chain 1, 1 chain 2
        logic aux_chain;
        logic [3:0] ctrl;
        logic [3:0] status;
        logic [3:0] mask;
        logic [DATA_W-1:0] rdata;
        logic irq;
        logic flushing;          // draining storage to standby
        logic sby_valid;
        logic resync;            // full refresh this scan
        logic [1:0] online_q;    // online history for edge find
        logic minor;
        logic major;
        logic bus_en;            // bus released in shutdown
        logic sby_dest;          // standby id, inverse of master from the first clock after reset
    } rsu_top_type;

    rsu_top_type r, next_r;

    // storage handshake
    logic push;
    logic pop;
    logic buf_empty;
    logic buf_full;
    logic [DATA_W-1:0] buf_rdata;

    // view of the present master and standby
    logic mst_valid;
    logic [1:0] mst_kind;
    logic [DATA_W-1:0] mst_data;
    logic mst_fault;
    logic sby_fault;
    logic sby_online;
    logic [2:0] kinds;
    logic kind_hit;
    logic forced;
    logic forced_id;
    logic capture_on;
    logic chain_bad;
    logic chain_alt_ok;
    logic aux_bad;
    logic aux_alt_ok;
    logic major_cond;
    logic minor_cond;
    logic overflow;

    // master-side mux; of the standby only its fault and online lines are looked at
    always_comb begin
        mst_valid = r.master ? second_processor_valid_i
                             : first_processor_valid_i;
        mst_kind = r.master ? second_processor_kind_i
                            : first_processor_kind_i;
        mst_data = r.master ? second_processor_data_i
                            : first_processor_data_i;
        mst_fault = r.master ? second_processor_fault_i
                             : first_processor_fault_i;
        sby_fault = r.master ? first_processor_fault_i
                             : second_processor_fault_i;
        sby_online = r.master ? first_processor_online_i
                              : second_processor_online_i;
    end

    // copy selection and fault conditions
    always_comb begin
        // source of the copy set: jumpers or software
        kinds = r.ctrl[CTRL_SRC_BIT] ?
            r.ctrl[CTRL_KIND_LSB +: 3] : jumper_kinds_i;
        // a refresh after return moves everything
        kind_hit = (mst_kind != KIND_NONE) &&
            (r.resync || kinds[mst_kind]);
        forced = (master_sel_i == SEL_FIRST) ||
            (master_sel_i == SEL_SECOND);
        forced_id = (master_sel_i == SEL_SECOND);
        // a failing master is not trusted for new data
        capture_on = (r.st == ST_RUN) && !mst_fault;
        push = capture_on && mst_valid && kind_hit && !buf_full;
        overflow = capture_on && mst_valid && kind_hit && buf_full;
        pop = r.flushing && !buf_empty;
        chain_bad = r.chain ? chain2_fault_i : chain1_fault_i;
        chain_alt_ok = dual_chain_i &&
            !(r.chain ? chain1_fault_i : chain2_fault_i);
        aux_bad = aux_fitted_i &&
            (r.aux_chain ? aux_chain2_fault_i : aux_chain1_fault_i);
        aux_alt_ok = aux_fitted_i && dual_chain_i &&
            !(r.aux_chain ? aux_chain1_fault_i : aux_chain2_fault_i);
        // shutdown: no healthy master or no usable main chain
        major_cond = (first_processor_fault_i &&
            second_processor_fault_i) ||
            (chain_bad && !chain_alt_ok);
        // anything degraded while the system still runs
        minor_cond = !major_cond && (first_processor_fault_i ||
            second_processor_fault_i || chain1_fault_i ||
            (dual_chain_i && chain2_fault_i) || aux_bad ||
            overflow || !sby_online);
    end

    // next-state logic for the whole block
    always_comb begin
        next_r = r;
        next_r.online_q = {first_processor_online_i,
                           second_processor_online_i};
        next_r.sby_valid = pop;
        next_r.minor = minor_cond;
        next_r.major = major_cond;
        // scan end starts draining storage to the standby
        if (sweep_end_i && r.st == ST_RUN) begin
            next_r.flushing = 1'b1;
        end else if (buf_empty && !push) begin
            next_r.flushing = 1'b0;
        end
        // refresh finishes at the first sweep end seen while running
        if (r.resync && sweep_end_i && r.st == ST_RUN) begin
            next_r.resync = 1'b0;
        end
        // standby coming back on line needs a full refresh
        if ((!r.online_q[1] && first_processor_online_i && r.master) ||
            (!r.online_q[0] && second_processor_online_i &&
             !r.master)) begin
            next_r.resync = 1'b1;
        end
        // chain choice: move off a failed chain when allowed
        if (r.st != ST_HOLD && chain_bad && chain_alt_ok) begin
            next_r.chain = !r.chain;
        end
        if (r.st != ST_HOLD && aux_bad && aux_alt_ok) begin
            next_r.aux_chain = !r.aux_chain;
        end
        // operating state
        case (r.st)
            ST_HOLD: begin
                if (run_hold_i) begin
                    next_r.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!run_hold_i) begin
                    next_r.st = ST_HOLD;
                end else if (!forced && mst_fault && !sby_fault &&
                             sby_online) begin
                    // drain what was captured before switching
                    next_r.st = ST_HANDOVER;
                    next_r.flushing = 1'b1;
                end
            end
            ST_HANDOVER: begin
                // swap only once storage and output are empty
                if (forced) begin
                    next_r.st = ST_RUN;
                end else if (buf_empty && !r.sby_valid) begin
                    next_r.master = !r.master;
                    next_r.st = ST_RUN;
                end
            end
            ST_SHUTDOWN: begin
                if (!major_cond) begin
                    next_r.st = ST_HOLD;
                end
            end
            default: begin
                next_r.st = ST_HOLD;
            end
        endcase
        if (major_cond) begin
            next_r.st = ST_SHUTDOWN;
            next_r.flushing = 1'b0;
        end
        // keyswitch forcing overrides fault-driven choice
        if (forced) begin
            next_r.master = forced_id;
        end
        // register writes; sticky bits clear on one, set wins
        if (reg_wr_i) begin
            case (reg_addr_i)
                REG_CTRL: next_r.ctrl = reg_wdata_i[3:0];
                REG_MASK: next_r.mask = reg_wdata_i[3:0];
                REG_STATUS: next_r.status = r.status & ~reg_wdata_i[3:0];
                default: begin
                end
            endcase
        end
        if (r.st == ST_HANDOVER && !forced && buf_empty &&
            !r.sby_valid && !major_cond) begin
            next_r.status[ST_HANDOVER_DONE] = 1'b1;
        end
        if (r.resync && sweep_end_i && r.st == ST_RUN) begin
            next_r.status[ST_RESYNC_DONE] = 1'b1;
        end
        if (minor_cond && !r.minor) begin
            next_r.status[ST_MINOR_EVT] = 1'b1;
        end
        if (major_cond && !r.major) begin
            next_r.status[ST_MAJOR_EVT] = 1'b1;
        end
        // read data stand only in the cycle after the strobe
        next_r.rdata = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                REG_CTRL: next_r.rdata = {12'h000, r.ctrl};
                REG_STATUS: next_r.rdata = {12'h000, r.status};
                REG_MASK: next_r.rdata = {12'h000, r.mask};
                REG_STATE: next_r.rdata = {7'h00, r.major, r.minor,
                    r.resync, r.aux_chain, r.chain, r.master, r.st,
                    r.flushing};
                default: next_r.rdata = '0;
            endcase
        end
        next_r.irq = |(next_r.status & next_r.mask);
        next_r.bus_en = (next_r.st != ST_SHUTDOWN);
        next_r.sby_dest = !next_r.master;
    end

    // single register stage for the whole block
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            r <= '{st: ST_HOLD, ctrl: CTRL_RESET, status: STATUS_RESET,
                   mask: MASK_RESET, online_q: 2'h3, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // storage between master read and standby write
    rsu_copy_buf u_buf (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .push_i(push),
        .data_i(mst_data),
        .pop_i(pop),
        .data_o(buf_rdata),
        .empty_o(buf_empty),
        .full_o(buf_full)
    );

    // peripheral and alarm relays
    rsu_relay_drive u_relay (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .master_i(r.master),
        .minor_i(r.minor),
        .major_i(r.major),
        .relay_o(relay_o),
        .minor_relay_o(minor_relay_o),
        .major_relay_o(major_relay_o)
    );

    // outputs, all from flops
    assign reg_rdata_o = r.rdata;
    assign irq_o = r.irq;
    assign sby_data_o = buf_rdata;
    assign sby_valid_o = r.sby_valid;
    assign sby_dest_o = r.sby_dest;
    assign io_bus_sel_o = r.master;
    assign io_bus_en_o = r.bus_en;
    assign chain_sel_o = r.chain;
    assign aux_chain_sel_o = r.aux_chain;

    a_forced_master: assert property (@(posedge mclk_i)
        disable iff (rst_i) master_sel_i == SEL_SECOND |=> r.master)
        else $error("forced master not kept");
    a_hold_no_copy: assert property (@(posedge mclk_i)
        disable iff (rst_i) r.st == ST_HOLD |-> !push)
        else $error("copy while holding");
    a_major_shutdown: assert property (@(posedge mclk_i)
        disable iff (rst_i)
        major_cond |=> r.st == ST_SHUTDOWN ##1 !major_relay_o)
        else $error("major fault did not shut down");
    a_handover_bound: assert property (@(posedge mclk_i)
        disable iff (rst_i)
        r.st == ST_HANDOVER |-> ##[1:40] r.st != ST_HANDOVER)
        else $error("handover too long");
    a_handover_clean: assert property (@(posedge mclk_i)
        disable iff (rst_i)
        r.st == ST_HANDOVER ##1 r.st == ST_RUN && $past(!forced)
        |-> $past(buf_empty) && $changed(r.master))
        else $error("handover left data behind");
    a_pop_output: assert property (@(posedge mclk_i)
        disable iff (rst_i) pop |=> sby_valid_o &&
        sby_data_o == $past(u_buf.r.mem[u_buf.r.rptr]))
        else $error("standby word lost");
    a_resync_all: assert property (@(posedge mclk_i)
        disable iff (rst_i) r.resync && capture_on && mst_valid
        && mst_kind != KIND_NONE && !buf_full |-> push)
        else $error("refresh skipped a word");
    a_chain_swap: assert property (@(posedge mclk_i)
        disable iff (rst_i) r.st == ST_RUN && chain_bad && chain_alt_ok
        |=> chain_sel_o != $past(chain_sel_o))
        else $error("failed chain kept");
    a_fault_handover: assert property (@(posedge mclk_i)
        disable iff (rst_i)
        r.st == ST_RUN && run_hold_i && !forced && mst_fault &&
        !sby_fault && sby_online && !major_cond
        |=> r.st == ST_HANDOVER)
        else $error("master fault ignored");
endmodule
`default_nettype wire

// [verif/rsu_cpu_model.sv]
// behavioural model of one redundant processor offering scan data
`timescale 1ns/100ps
`default_nettype none
module rsu_cpu_model import rsu_pkg::*; #(
    parameter logic [DATA_W-1:0] BASE = 16'h1000
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic scan_i,
    input wire logic [3:0] count_i,
    output logic valid_o,
    output logic [1:0] kind_o,
    output logic [DATA_W-1:0] data_o,
    output logic sweep_end_o
);
    logic busy; // scan in progress
    logic [3:0] idx; // word index, also picks the kind
    logic [3:0] left; // words still to send
    logic [DATA_W-1:0] noise; // idle bus never holds the last word

    // one word a cycle, kinds cycle through all four codes, then sweep end
    always_ff @(posedge mclk_i) begin
        noise <= noise + 16'h3B5D;
        kind_o <= noise[1:0];
        data_o <= noise;
        valid_o <= 1'h0;
        sweep_end_o <= 1'h0;
        if (rst_i) begin
            busy <= 1'h0;
            noise <= BASE;
        end else if (scan_i) begin
            busy <= 1'h1;
            idx <= 4'h0;
            left <= count_i;
        end else if (busy && left == 4'h0) begin
            busy <= 1'h0;
            sweep_end_o <= 1'h1;
        end else if (busy) begin
            valid_o <= 1'h1; // offered set of kinds
            kind_o <= idx[1:0];
            data_o <= BASE + DATA_W'(idx);
            idx <= idx + 4'h1;
            left <= left - 4'h1;
        end
    end
endmodule
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench of the redundancy switch unit
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import rsu_pkg::*;
    logic mclk_i, rst_i, reg_wr_i, reg_rd_i, irq_o;
    logic [ADDR_W-1:0] reg_addr_i;
    logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, sby_data_o, d;
    logic run_hold_i, dual_chain_i, aux_fitted_i, sweep_end_i;
    logic [1:0] master_sel_i, first_processor_kind_i, second_processor_kind_i;
    logic [2:0] jumper_kinds_i;
    logic first_processor_valid_i, first_processor_fault_i;
    logic first_processor_online_i, second_processor_online_i;
    logic second_processor_valid_i, second_processor_fault_i;
    logic [DATA_W-1:0] first_processor_data_i, second_processor_data_i;
    logic chain1_fault_i, chain2_fault_i, aux_chain1_fault_i;
    logic aux_chain2_fault_i, sby_valid_o, sby_dest_o, io_bus_sel_o;
    logic io_bus_en_o, chain_sel_o, aux_chain_sel_o;
    logic minor_relay_o, major_relay_o;
    logic [RELAY_COUNT-1:0] relay_o;
    logic [1:0] scan, s_end; // per processor scan request and sweep end
    logic [3:0] count;
    int n_mismatch, n_tests;
    logic [DATA_W-1:0] got[$]; // words seen on the standby path

    assign sweep_end_i = |s_end;

    rsu_top i_rsu_top (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o, .run_hold_i,
        .master_sel_i, .jumper_kinds_i, .dual_chain_i, .aux_fitted_i,
        .first_processor_valid_i, .first_processor_kind_i,
        .first_processor_data_i, .first_processor_fault_i,
        .first_processor_online_i, .second_processor_valid_i,
        .second_processor_kind_i, .second_processor_data_i,
        .second_processor_fault_i, .second_processor_online_i,
        .sweep_end_i, .chain1_fault_i, .chain2_fault_i, .aux_chain1_fault_i,
        .aux_chain2_fault_i, .sby_data_o, .sby_valid_o, .sby_dest_o,
        .io_bus_sel_o, .io_bus_en_o, .chain_sel_o, .aux_chain_sel_o,
        .relay_o, .minor_relay_o, .major_relay_o);
    rsu_cpu_model #(.BASE(16'hA000)) i_rsu_cpu_model (.mclk_i, .rst_i,
        .scan_i(scan[0]), .count_i(count),
        .valid_o(first_processor_valid_i), .kind_o(first_processor_kind_i),
        .data_o(first_processor_data_i), .sweep_end_o(s_end[0]));
    rsu_cpu_model #(.BASE(16'h5000)) i_rsu_cpu_model_2 (.mclk_i, .rst_i,
        .scan_i(scan[1]), .count_i(count),
        .valid_o(second_processor_valid_i), .kind_o(second_processor_kind_i),
        .data_o(second_processor_data_i), .sweep_end_o(s_end[1]));

    // free running clock
    initial begin
        mclk_i = 1'h0;
        forever #5 mclk_i = ~mclk_i;
    end

    // collect standby words for later comparison
    always @(posedge mclk_i) begin
        if (sby_valid_o === 1'h1) got.push_back(sby_data_o);
    end

    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task settle(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge mclk_i);
        reg_wr_i <= 1'h1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge mclk_i);
        reg_wr_i <= 1'h0;
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a);
        @(posedge mclk_i);
        reg_rd_i <= 1'h1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'h0;
        #1 d = reg_rdata_o;
    endtask
    // bounded wait: n words plus sweep end plus the drain
    task scan_cpu(input int who, input int n);
        got.delete();
        @(posedge mclk_i);
        scan[who] <= 1'h1;
        count <= n[3:0];
        @(posedge mclk_i);
        scan[who] <= 1'h0;
        settle(2 * n + 12);
    endtask
    task two_words(input logic [15:0] a, input logic [15:0] b);
        check(16'(got.size()), 16'h2);
        if (got.size() >= 2) begin
            check(got[0], a);
            check(got[1], b);
        end
    endtask

    task t_reset;
        rd(REG_CTRL);
        check(d, 16'h0);
        rd(REG_STATUS);
        check(d, 16'h0);
        wr(8'h10, 16'hFFFF);
        rd(8'h10);
        check(d, 16'h0);
        check(16'(relay_o), 16'h0);
        check(16'(major_relay_o), 16'h1);
        rd(REG_STATE);
        check(d & 16'h6, 16'h0);
    endtask
    task t_hold_copy;
        scan_cpu(0, 4);
        check(16'(got.size()), 16'h0);
        @(posedge mclk_i) run_hold_i <= 1'h1;
        rd(REG_STATE);
        check(d & 16'h6, 16'h2);
        scan_cpu(0, 8);
        two_words(16'hA000, 16'hA004);
        check(16'(sby_dest_o), 16'h1);
        wr(REG_CTRL, 16'h9);
        rd(REG_CTRL);
        check(d, 16'h9);
        scan_cpu(0, 8);
        two_words(16'hA002, 16'hA006);
        wr(REG_CTRL, 16'h0);
    endtask
    // handover on master fault, with the interrupt raised, masked, cleared
    task t_handover;
        wr(REG_MASK, 16'h1);
        @(posedge mclk_i) first_processor_fault_i <= 1'h1;
        settle(30);
        check(16'(io_bus_sel_o), 16'h1);
        check(16'(relay_o), 16'hFFF);
        check(16'(irq_o), 16'h1);
        wr(REG_MASK, 16'h0);
        settle(2);
        check(16'(irq_o), 16'h0);
        wr(REG_MASK, 16'h1);
        wr(REG_STATUS, 16'h1);
        settle(2);
        check(16'(irq_o), 16'h0);
        @(posedge mclk_i) first_processor_fault_i <= 1'h0;
    endtask
    task t_force_chain;
        @(posedge mclk_i) master_sel_i <= SEL_FIRST;
        settle(3);
        check(16'(io_bus_sel_o), 16'h0);
        @(posedge mclk_i) master_sel_i <= SEL_SECOND;
        settle(3);
        check(16'(io_bus_sel_o), 16'h1);
        @(posedge mclk_i) master_sel_i <= SEL_FIRST;
        settle(3);
        @(posedge mclk_i) first_processor_fault_i <= 1'h1;
        settle(30);
        check(16'(io_bus_sel_o), 16'h0);
        @(posedge mclk_i) first_processor_fault_i <= 1'h0;
        {dual_chain_i, aux_fitted_i, chain1_fault_i, aux_chain1_fault_i} <= '1;
        settle(3);
        check(16'({chain_sel_o, aux_chain_sel_o}), 16'h3);
        {chain1_fault_i, aux_chain1_fault_i} <= '0;
    endtask
    task t_alarms;
        @(posedge mclk_i) second_processor_online_i <= 1'h0;
        settle(3);
        check(16'(minor_relay_o), 16'h0);
        @(posedge mclk_i) second_processor_online_i <= 1'h1;
        scan_cpu(0, 0);
        rd(REG_STATUS);
        check(d & 16'hA, 16'hA);
        {first_processor_fault_i, second_processor_fault_i} <= '1;
        settle(3);
        check(16'({major_relay_o, io_bus_en_o}), 16'h0);
        rd(REG_STATE);
        check(d & 16'h6, 16'h6);
    endtask

    task report_and_stop;
        if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // reset, then the scenarios in order
    initial begin
        {reg_wr_i, reg_rd_i, run_hold_i, dual_chain_i, aux_fitted_i} = '0;
        {master_sel_i, scan, count, reg_addr_i, reg_wdata_i} = '0;
        {first_processor_fault_i, second_processor_fault_i} = '0;
        {chain1_fault_i, chain2_fault_i, aux_chain1_fault_i} = '0;
        aux_chain2_fault_i = 1'h0;
        {first_processor_online_i, second_processor_online_i} = '1;
        jumper_kinds_i = 3'h1;
        rst_i = 1'h1;
        settle(8);
        rst_i <= 1'h0;
        t_reset();
        t_hold_copy();
        t_handover();
        t_force_chain();
        t_alarms();
        report_and_stop();
    end
endmodule
`default_nettype wire
